// file: logic/pbm_port_mux.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "pbm_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - spi slave forces clock pin input
// - forced input keeps latch pull-up
// - spi master forces pin1 input
// - spi slave forces pin0 input
// - pin1 carries timer0 b when output
// - pin0 carries timer0 a when output
// - timer1 inverted pin0, true pin1
// - three-wire data out on pin1
// - reference use disables pin0 pull/driver
// - pin5 fuses gate pull-up and direction
// - pin5 input enable override
// - pins 4..2 input enable override
// - pin2 two-wire open-drain clock
// - pin0 two-wire open-drain data
// - pin0 value override from timers
// - pin1 input enable override
// - pin0 input enable override
// - global disable turns latch-driven pull-ups off
// - pull-up override value wins
// - direction override drives enable
// - value override replaces latch
// - input enable override or sleep
module pbm_port_mux
(
    input wire logic mclk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripherals and fuses
    input wire pbm_pkg::pbm_periph_t periph,
    input wire logic reset_pin_disable_fuse_n,
    input wire logic debug_link_fuse_n,
    input wire logic sleep_state,
    // pad controls
    output logic [5:0] pad_oe,
    output logic [5:0] pad_out,
    output logic [5:0] pad_pullup,
    output logic [5:0] pad_din_en
);
    pbm_pkg::pbm_state_t s_q;
    pbm_pkg::pbm_state_t s_d;
    pbm_pkg::pbm_ovr_t ovr [6];
    pbm_pkg::pbm_pins_t pins_c;

    ////////////////////////////////////////////////////////////////////////////
    // decoded config
    logic spi_en;
    logic spi_master;
    logic serial_two_wire_mode;
    logic serial_three_wire_mode;
    logic external_analog_reference_use;
    logic pcie;
    logic global_pullup_disable;
    logic fuse_gate;
    logic [7:0] lat;
    logic [7:0] dir;

    // word-aligned decode shared by read and write
    function automatic logic [2:0] pbm_dec(input logic [11:0] a);
        case (a)
            `PBM_ADDR_LATCH: pbm_dec = 3'd1;
            `PBM_ADDR_MCUCTL: pbm_dec = 3'd2;
            `PBM_ADDR_DIR: pbm_dec = 3'd3;
            `PBM_ADDR_PERIPH: pbm_dec = 3'd4;
            `PBM_ADDR_STATUS: pbm_dec = 3'd5;
            default: pbm_dec = 3'd0;
        endcase
    endfunction : pbm_dec

    always_comb
    begin
        lat = s_q.latch;
        dir = s_q.dir;
        spi_en = s_q.periph[`PBM_P_SPI_EN];
        spi_master = s_q.periph[`PBM_P_SPI_MASTER];
        serial_two_wire_mode = s_q.periph[`PBM_P_TWO_WIRE];
        serial_three_wire_mode = s_q.periph[`PBM_P_THREE_WIRE];
        external_analog_reference_use = s_q.periph[`PBM_P_EXTERNAL_ANALOG_REFERENCE];
        pcie = s_q.periph[`PBM_P_PCIE];
        global_pullup_disable = s_q.mcuctl[`PBM_PUD_BIT];
        // fuse inputs read 0 when programmed
        fuse_gate = !reset_pin_disable_fuse_n && !debug_link_fuse_n;
    end

    ////////////////////////////////////////////////////////////////////////////
    // override generation per pin
    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            ovr[i] = '0;
        end
        ovr[5].pullup_override_enable = fuse_gate;
        ovr[5].pullup_override_value = 1'b1;
        ovr[5].direction_override_enable = fuse_gate;
        ovr[5].direction_override_value = periph.debug_tx;
        ovr[5].input_enable_override_enable = !reset_pin_disable_fuse_n
            || (periph.pin_change_mask[5] && pcie) || periph.converter_ch0_digital_off;
        ovr[5].input_enable_override_value = periph.converter_ch0_digital_off;
        // timer1 b true on pin4, inverted on pin3
        ovr[4].value_override_enable = periph.timer1_compare_b_en;
        ovr[4].value_override_value = periph.timer1_compare_b_out;
        ovr[3].value_override_enable = periph.timer1_compare_b_en;
        ovr[3].value_override_value = !periph.timer1_compare_b_out;
        ovr[4].input_enable_override_enable = (periph.pin_change_mask[4] && pcie)
            || periph.converter_ch2_digital_off;
        ovr[4].input_enable_override_value = periph.converter_ch2_digital_off;
        ovr[3].input_enable_override_enable = (periph.pin_change_mask[3] && pcie)
            || periph.converter_ch3_digital_off;
        ovr[3].input_enable_override_value = periph.converter_ch3_digital_off;
        ovr[2].input_enable_override_enable = (periph.pin_change_mask[2] && pcie)
            || periph.converter_ch1_digital_off || periph.serial_start_irq_enable;
        ovr[2].input_enable_override_value = periph.converter_ch1_digital_off;

        // pin2: serial clock
        if (serial_two_wire_mode)
        begin
            ovr[2].pullup_override_enable = 1'b1;
            ovr[2].direction_override_enable = 1'b1;
            ovr[2].direction_override_value = (periph.two_wire_clock_stretch || lat[2]) && dir[2];
            ovr[2].value_override_enable = dir[2];
        end
        else if (spi_en && !spi_master)
        begin
            // slave clock forced input; pull-up stays latch-driven
            ovr[2].direction_override_enable = 1'b1;
        end
        ovr[2].toggle_override_enable = periph.serial_clock_toggle_strobe;

        // pin1: data out / timers
        if (spi_en && spi_master)
        begin
            ovr[1].direction_override_enable = 1'b1;
        end
        // value only reaches pad when direction set
        ovr[1].value_override_enable = periph.timer0_compare_b_en || periph.timer1_compare_a_en
            || serial_three_wire_mode;
        ovr[1].value_override_value = (periph.timer0_compare_b_en && periph.timer0_compare_b_out)
            || (periph.timer1_compare_a_en && periph.timer1_compare_a_out)
            || (serial_three_wire_mode && periph.serial_data_out);
        ovr[1].input_enable_override_enable = (periph.pin_change_mask[1] && pcie)
            || periph.comparator_minus_digital_off;
        ovr[1].input_enable_override_value = periph.comparator_minus_digital_off;

        // pin0: data / reference
        if (external_analog_reference_use)
        begin
            ovr[0].pullup_override_enable = 1'b1;
            ovr[0].direction_override_enable = 1'b1;
        end
        else if (serial_two_wire_mode)
        begin
            ovr[0].pullup_override_enable = 1'b1;
            ovr[0].direction_override_enable = 1'b1;
            ovr[0].direction_override_value = (periph.two_wire_sda_out || lat[0]) && dir[0];
        end
        else if (spi_en && !spi_master)
        begin
            ovr[0].direction_override_enable = 1'b1;
        end
        ovr[0].value_override_enable = periph.timer0_compare_a_en || periph.timer1_compare_a_en
            || (serial_two_wire_mode && dir[0]);
        ovr[0].value_override_value = (periph.timer0_compare_a_en && periph.timer0_compare_a_out)
            || (periph.timer1_compare_a_en && !periph.timer1_compare_a_out);
        ovr[0].input_enable_override_enable = (periph.pin_change_mask[0] && pcie)
            || periph.comparator_plus_digital_off || periph.serial_start_irq_enable;
        ovr[0].input_enable_override_value = periph.comparator_plus_digital_off;
    end

    ////////////////////////////////////////////////////////////////////////////
    // generic pin cells
    genvar g;
    generate
        for (g = 0; g < 6; g++)
        begin : g_pin
            pbm_pin_cell u_cell
            (
                .ovr(ovr[g]),
                .dir_bit(dir[g]),
                .latch_bit(lat[g]),
                .global_pullup_disable(global_pullup_disable),
                .sleep_state(sleep_state),
                .oe(pins_c.oe[g]),
                .out(pins_c.out[g]),
                .pull_on(pins_c.pull_on[g]),
                .din_en(pins_c.din_en[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // next state: apb slave and pad register
    always_comb
    begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.pins = pins_c;
        case (s_q.st)
            pbm_pkg::PBM_IDLE:
            begin
                // setup seen, answer next cycle
                if (psel && !penable)
                begin
                    s_d.st = pbm_pkg::PBM_ACC;
                    s_d.pready = 1'b1;
                    s_d.prdata = '0;
                    case (pbm_dec(paddr))
                        3'd1: s_d.prdata[7:0] = s_q.latch;
                        3'd2: s_d.prdata[7:0] = s_q.mcuctl;
                        3'd3: s_d.prdata[7:0] = s_q.dir;
                        3'd4: s_d.prdata[7:0] = s_q.periph;
                        3'd5: s_d.prdata[23:0] = {pins_c.din_en, pins_c.pull_on, pins_c.oe, pins_c.out};
                        default: s_d.pslverr = 1'b1;
                    endcase
                    if (pwrite && pbm_dec(paddr) == 3'd5)
                    begin
                        s_d.pslverr = 1'b1;
                    end
                end
            end
            pbm_pkg::PBM_ACC:
            begin
                s_d.st = pbm_pkg::PBM_IDLE;
                // write takes effect on the completing edge
                if (psel && penable && pwrite)
                begin
                    case (pbm_dec(paddr))
                        3'd1: s_d.latch = pwdata[7:0] & `PBM_LATCH_MASK;
                        3'd2: s_d.mcuctl = pwdata[7:0] & `PBM_MCUCTL_MASK;
                        3'd3: s_d.dir = pwdata[7:0] & `PBM_DIR_MASK;
                        3'd4: s_d.periph = pwdata[7:0];
                        default: s_d.st = pbm_pkg::PBM_IDLE;
                    endcase
                end
            end
            default: s_d.st = pbm_pkg::PBM_IDLE;
        endcase
    end

    // single state register, synchronous reset
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            s_q <= '0;
            s_q.st <= pbm_pkg::PBM_IDLE;
            s_q.latch <= `PBM_LATCH_RST;
            s_q.mcuctl <= `PBM_MCUCTL_RST;
            s_q.dir <= `PBM_DIR_RST;
            s_q.periph <= `PBM_PERIPH_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign pad_oe = s_q.pins.oe;
    assign pad_out = s_q.pins.out;
    assign pad_pullup = s_q.pins.pull_on;
    assign pad_din_en = s_q.pins.din_en;
endmodule : pbm_port_mux

// file: logic/pbm_map.svh
`ifndef PBM_MAP_SVH
`define PBM_MAP_SVH
// register indices; the byte address is four times the index
`define PBM_IDX_LATCH 8'h18
`define PBM_IDX_MCUCTL 8'h35
`define PBM_ADDR_LATCH 12'h060
`define PBM_ADDR_MCUCTL 12'h0D4
// own control registers
`define PBM_ADDR_DIR 12'h100
`define PBM_ADDR_PERIPH 12'h104
`define PBM_ADDR_STATUS 12'h108
// field positions
`define PBM_LATCH_MASK 8'h3F
`define PBM_MCUCTL_MASK 8'h7B
`define PBM_PUD_BIT 6
`define PBM_DIR_MASK 8'h3F
// reset values
`define PBM_LATCH_RST 8'h00
`define PBM_MCUCTL_RST 8'h00
`define PBM_DIR_RST 8'h00
`define PBM_PERIPH_RST 8'h00
// periph config fields
`define PBM_P_SPI_EN 0
`define PBM_P_SPI_MASTER 1
`define PBM_P_TWO_WIRE 2
`define PBM_P_THREE_WIRE 3
`define PBM_P_EXTERNAL_ANALOG_REFERENCE 4
`define PBM_P_PCIE 5
`endif

// file: logic/pbm_pkg.sv
package pbm_pkg;
    // per-pin override bundle
    typedef struct packed {
        logic pullup_override_enable;
        logic pullup_override_value;
        logic direction_override_enable;
        logic direction_override_value;
        logic value_override_enable;
        logic value_override_value;
        logic toggle_override_enable;
        logic input_enable_override_enable;
        logic input_enable_override_value;
    } pbm_ovr_t;

    // inputs from peripherals
    typedef struct packed {
        logic two_wire_clock_stretch;
        logic serial_clock_toggle_strobe;
        logic serial_start_irq_enable;
        logic serial_data_out;
        logic two_wire_sda_out;
        logic timer0_compare_a_out;
        logic timer0_compare_a_en;
        logic timer0_compare_b_out;
        logic timer0_compare_b_en;
        logic timer1_compare_a_out;
        logic timer1_compare_a_en;
        logic timer1_compare_b_out;
        logic timer1_compare_b_en;
        logic debug_tx;
        logic [5:0] pin_change_mask;
        logic converter_ch0_digital_off;
        logic converter_ch1_digital_off;
        logic converter_ch2_digital_off;
        logic converter_ch3_digital_off;
        logic comparator_plus_digital_off;
        logic comparator_minus_digital_off;
    } pbm_periph_t;

    // pin drive result
    typedef struct packed {
        logic [5:0] oe;
        logic [5:0] out;
        logic [5:0] pull_on;
        logic [5:0] din_en;
    } pbm_pins_t;

    typedef enum logic [1:0] {
        PBM_IDLE = 2'b01,
        PBM_ACC = 2'b10
    } pbm_bus_st_t;

    typedef struct packed {
        pbm_bus_st_t st;
        logic [7:0] latch;
        logic [7:0] mcuctl;
        logic [7:0] dir;
        logic [7:0] periph;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        pbm_pins_t pins;
    } pbm_state_t;
endpackage : pbm_pkg

// file: logic/pbm_pin_cell.sv
`timescale 1ns/1ps
// generic port pin: applies override bundle to register bits
module pbm_pin_cell
(
    input wire pbm_pkg::pbm_ovr_t ovr,
    input wire logic dir_bit,
    input wire logic latch_bit,
    input wire logic global_pullup_disable,
    input wire logic sleep_state,
    output logic oe,
    output logic out,
    output logic pull_on,
    output logic din_en
);
    logic latch_eff;

    always_comb
    begin
        latch_eff = latch_bit ^ ovr.toggle_override_enable;
        oe = ovr.direction_override_enable ? ovr.direction_override_value : dir_bit;
        out = ovr.value_override_enable ? ovr.value_override_value : latch_eff;
        if (ovr.pullup_override_enable)
        begin
            pull_on = ovr.pullup_override_value;
        end
        else
        begin
            pull_on = !oe && latch_bit && !global_pullup_disable;
        end
        din_en = ovr.input_enable_override_enable ? ovr.input_enable_override_value : !sleep_state;
    end
endmodule : pbm_pin_cell

// file: sim/pbm_port_mux_monitor.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// port checker, sees only the top ports
module pbm_port_mux_monitor
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire pbm_pkg::pbm_periph_t periph,
    input wire logic reset_pin_disable_fuse_n,
    input wire logic debug_link_fuse_n,
    input wire logic sleep_state,
    input wire logic [5:0] pad_oe,
    input wire logic [5:0] pad_out,
    input wire logic [5:0] pad_pullup,
    input wire logic [5:0] pad_din_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////
    // pads quiet at release
    chk_reset_pads_quiet: assert property ($rose(rstn) |-> pad_oe == 6'h0 && pad_pullup == 6'h0)
        else $error("pads active right after reset");
    chk_fuse_pin5_drive: assert property (
        $past(rstn) && !reset_pin_disable_fuse_n && !debug_link_fuse_n
        |=> pad_pullup[5] && pad_oe[5] == $past(periph.debug_tx)) else $error("pin5 fuse override wrong");
    chk_pin5_din_follow: assert property (
        $past(rstn) && (!reset_pin_disable_fuse_n || periph.converter_ch0_digital_off)
        |=> pad_din_en[5] == $past(periph.converter_ch0_digital_off)) else $error("pin5 input enable wrong");
    chk_ch3_din_on: assert property (
        $past(rstn) && periph.converter_ch3_digital_off |=> pad_din_en[3]) else $error("pin3 input enable wrong");
    chk_start_pin2_off: assert property (
        $past(rstn) && periph.serial_start_irq_enable && !periph.converter_ch1_digital_off
        |=> !pad_din_en[2]) else $error("pin2 input enable wrong");
    chk_cmp_minus_din: assert property (
        $past(rstn) && periph.comparator_minus_digital_off |=> pad_din_en[1]) else $error("pin1 input enable wrong");
    chk_start_pin0_off: assert property (
        $past(rstn) && periph.serial_start_irq_enable && !periph.comparator_plus_digital_off
        |=> !pad_din_en[0]) else $error("pin0 input enable wrong");
    chk_t1b_pin_pair: assert property (
        $past(rstn) && pad_oe[4] && pad_oe[3] && $past(periph.timer1_compare_b_en)
        |-> pad_out[4] == $past(periph.timer1_compare_b_out) && pad_out[3] != pad_out[4])
        else $error("pin3 pin4 compare value wrong");
    // zero wait state, single pulse answer
    chk_ready_one_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single pulse");
    // error only alongside ready
    chk_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    cover property (psel && penable && pready && pwrite);
    cover property (pslverr);
    cover property (!debug_link_fuse_n && !reset_pin_disable_fuse_n && periph.debug_tx);
endmodule : pbm_port_mux_monitor

bind pbm_port_mux pbm_port_mux_monitor u_mon (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph(periph), .reset_pin_disable_fuse_n(reset_pin_disable_fuse_n), .debug_link_fuse_n(debug_link_fuse_n),
    .sleep_state(sleep_state), .pad_oe(pad_oe), .pad_out(pad_out), .pad_pullup(pad_pullup),
    .pad_din_en(pad_din_en));

// file: sim/pbm_pad_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// outside circuit on the six pads
module pbm_pad_model
(
    input wire logic mclk,
    input wire logic [5:0] pad_oe,
    input wire logic [5:0] pad_out,
    input wire logic [5:0] pad_pullup,
    output logic [5:0] pin_lvl
);
    // undriven, unpulled pads wander so no stale level passes
    logic [5:0] float_q = 6'h15;
    always_ff @(posedge mclk)
        float_q <= ~float_q;
    // driver wins, then pull-up, else floating
    assign pin_lvl = (pad_oe & pad_out) | (~pad_oe & pad_pullup) | (~pad_oe & ~pad_pullup & float_q);
endmodule : pbm_pad_model

// file: sim/pbm_port_mux_test.sv
`timescale 1ns/1ps
`include "pbm_map.svh"
module pbm_port_mux_test;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pbm_pkg::pbm_periph_t periph = '0;
    logic rst_fuse_n = 1'b1;
    logic dbg_fuse_n = 1'b1;
    logic sleep_state = 1'b0;
    logic [5:0] pad_oe;
    logic [5:0] pad_out;
    logic [5:0] pad_pullup;
    logic [5:0] pad_din_en;
    logic [5:0] pin_lvl;
    logic [31:0] rdata;
    logic rerr;
    int err_total = 0;
    int check_count = 0;
    always #5 mclk = ~mclk;
    pbm_port_mux dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph(periph),
        .reset_pin_disable_fuse_n(rst_fuse_n), .debug_link_fuse_n(dbg_fuse_n), .sleep_state(sleep_state),
        .pad_oe(pad_oe), .pad_out(pad_out), .pad_pullup(pad_pullup), .pad_din_en(pad_din_en));
    pbm_pad_model pads (.mclk(mclk), .pad_oe(pad_oe), .pad_out(pad_out), .pad_pullup(pad_pullup), .pin_lvl(pin_lvl));
    ////////////////////////////////////////////////////////////////////////////
    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk
    task c1(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask : c1
    // one apb transfer, held until ready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            $display("wrong value pready expected 1 seen timeout");
            err_total++;
            wrap_up();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rdata);
    endtask : rdc
    // pads are registered: let changes land
    task st;
        repeat (3) @(posedge mclk);
    endtask : st
    task cfg(input logic [7:0] pe, input logic [7:0] dr, input logic [7:0] la);
        apb(1'b1, `PBM_ADDR_PERIPH, {24'h0, pe});
        apb(1'b1, `PBM_ADDR_DIR, {24'h0, dr});
        apb(1'b1, `PBM_ADDR_LATCH, {24'h0, la});
        st();
    endtask : cfg
    ////////////////////////////////////////////////////////////////////////////
    task t_regs;
        rdc("latch reset", `PBM_ADDR_LATCH, 32'h0000_0000);
        rdc("control reset", `PBM_ADDR_MCUCTL, 32'h0000_0000);
        apb(1'b1, `PBM_ADDR_LATCH, 32'h0000_00FF);
        rdc("latch top bits", `PBM_ADDR_LATCH, 32'h0000_003F);
        apb(1'b1, `PBM_ADDR_MCUCTL, 32'h0000_00FF);
        rdc("control read only bits", `PBM_ADDR_MCUCTL, 32'h0000_007B);
        apb(1'b1, `PBM_ADDR_MCUCTL, 32'h0000_0000);
        apb(1'b0, 12'h200, 32'h0000_0000);
        c1("unmapped error", 1'b1, rerr);
        apb(1'b1, `PBM_ADDR_STATUS, 32'h0000_0000);
        c1("status write error", 1'b1, rerr);
    endtask : t_regs
    task t_pullup;
        cfg(8'h00, 8'h00, 8'h3F);
        c1("pin3 pin level", 1'b1, pin_lvl[3]);
        apb(1'b1, `PBM_ADDR_MCUCTL, 32'h0000_0040);
        st();
        c1("pin3 pull-up off", 1'b0, pad_pullup[3]);
        rst_fuse_n <= 1'b0;
        dbg_fuse_n <= 1'b0;
        st();
        c1("pin5 forced pull-up", 1'b1, pad_pullup[5]);
        rst_fuse_n <= 1'b1;
        dbg_fuse_n <= 1'b1;
        apb(1'b1, `PBM_ADDR_MCUCTL, 32'h0000_0000);
    endtask : t_pullup
    task t_spi;
        cfg(8'h01, 8'h07, 8'h04);
        c1("slave clock dir", 1'b0, pad_oe[2]);
        c1("slave in dir", 1'b0, pad_oe[0]);
        c1("slave out dir", 1'b1, pad_oe[1]);
        c1("forced input pull-up", 1'b1, pad_pullup[2]);
        cfg(8'h03, 8'h07, 8'h00);
        c1("master clock dir", 1'b1, pad_oe[2]);
        c1("master out dir", 1'b1, pad_oe[0]);
        c1("master in dir", 1'b0, pad_oe[1]);
    endtask : t_spi
    task t_timer;
        cfg(8'h00, 8'h1B, 8'h00);
        periph.timer0_compare_a_en <= 1'b1;
        periph.timer0_compare_a_out <= 1'b1;
        periph.timer0_compare_b_en <= 1'b1;
        periph.timer1_compare_b_en <= 1'b1;
        periph.timer1_compare_b_out <= 1'b1;
        st();
        c1("pin0 timer0 a", 1'b1, pad_out[0]);
        c1("pin1 timer0 b", 1'b0, pad_out[1]);
        c1("pin3 inverted b", 1'b0, pad_out[3]);
        periph <= '0;
        @(posedge mclk);
        for (int v = 0; v < 2; v++)
        begin
            periph.timer1_compare_a_en <= 1'b1;
            periph.timer1_compare_a_out <= v[0];
            st();
            c1("pin0 timer1 inverted", ~v[0], pad_out[0]);
            c1("pin1 timer1 true", v[0], pad_out[1]);
        end
        cfg(8'h00, 8'h00, 8'h00);
        c1("pin1 undriven", 1'b0, pad_oe[1]);
        periph <= '0;
    endtask : t_timer
    task t_two_wire;
        cfg(8'h04, 8'h05, 8'h01);
        c1("clock released", 1'b0, pad_oe[2]);
        c1("data pulled low", 1'b1, pad_oe[0]);
        c1("data value zero", 1'b0, pad_out[0]);
        periph.two_wire_clock_stretch <= 1'b1;
        st();
        c1("clock held low", 1'b1, pad_oe[2]);
        c1("clock value zero", 1'b0, pad_out[2]);
        periph <= '0;
        cfg(8'h04, 8'h00, 8'h05);
        c1("data no pull-up", 1'b0, pad_pullup[0]);
        c1("clock no pull-up", 1'b0, pad_pullup[2]);
    endtask : t_two_wire
    task t_toggle;
        cfg(8'h00, 8'h04, 8'h00);
        periph.serial_clock_toggle_strobe <= 1'b1;
        st();
        c1("toggled clock", 1'b1, pad_out[2]);
        periph.serial_clock_toggle_strobe <= 1'b0;
        st();
        c1("clock back", 1'b0, pad_out[2]);
    endtask : t_toggle
    task t_three_wire;
        // software keeps pin0 an input to receive
        cfg(8'h08, 8'h02, 8'h00);
        periph.serial_data_out <= 1'b1;
        st();
        c1("data out on pin1", 1'b1, pad_out[1]);
        c1("pin0 stays input", 1'b0, pad_oe[0]);
        cfg(8'h08, 8'h00, 8'h02);
        c1("input pull-up kept", 1'b1, pad_pullup[1]);
        periph <= '0;
    endtask : t_three_wire
    task t_external_analog_reference;
        cfg(8'h10, 8'h00, 8'h01);
        c1("reference pull-up", 1'b0, pad_pullup[0]);
        cfg(8'h10, 8'h01, 8'h01);
        c1("reference driver", 1'b0, pad_oe[0]);
        cfg(8'h20, 8'h00, 8'h00);
        periph.pin_change_mask[4] <= 1'b1;
        st();
        c1("pin4 change override", 1'b0, pad_din_en[4]);
        periph <= '0;
    endtask : t_external_analog_reference
    task t_din;
        sleep_state <= 1'b1;
        rst_fuse_n <= 1'b0;
        st();
        c1("pin5 disable bit low", 1'b0, pad_din_en[5]);
        c1("pin4 asleep", 1'b0, pad_din_en[4]);
        periph.converter_ch0_digital_off <= 1'b1;
        periph.converter_ch2_digital_off <= 1'b1;
        periph.converter_ch3_digital_off <= 1'b1;
        periph.comparator_minus_digital_off <= 1'b1;
        st();
        c1("pin3 override", 1'b1, pad_din_en[3]);
        c1("pin5 disable bit high", 1'b1, pad_din_en[5]);
        c1("pin4 override", 1'b1, pad_din_en[4]);
        c1("pin1 override", 1'b1, pad_din_en[1]);
        periph <= '0;
        sleep_state <= 1'b0;
        st();
        c1("pin0 awake", 1'b1, pad_din_en[0]);
        periph.serial_start_irq_enable <= 1'b1;
        dbg_fuse_n <= 1'b0;
        periph.debug_tx <= 1'b1;
        st();
        c1("pin0 start override", 1'b0, pad_din_en[0]);
        c1("pin2 start override", 1'b0, pad_din_en[2]);
        c1("pin5 debug drive", 1'b1, pad_oe[5]);
        periph.debug_tx <= 1'b0;
        st();
        c1("pin5 debug release", 1'b0, pad_oe[5]);
    endtask : t_din
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        t_regs();
        t_pullup();
        t_spi();
        t_timer();
        t_two_wire();
        t_toggle();
        t_three_wire();
        t_external_analog_reference();
        t_din();
        wrap_up();
    end
endmodule : pbm_port_mux_test
